// file: hdl/aclm_defines.svh
// register offsets, field positions, reset values and header codes of the entry matcher
`ifndef ACLM_DEFINES_SVH
`define ACLM_DEFINES_SVH

`define ACLM_OFF_CTRL 8'h00
`define ACLM_OFF_ARP 8'h04
`define ACLM_OFF_IP 8'h08
`define ACLM_OFF_SRC_ADDR 8'h0c
`define ACLM_OFF_SRC_MASK 8'h10
`define ACLM_OFF_DST_ADDR 8'h14
`define ACLM_OFF_DST_MASK 8'h18
`define ACLM_OFF_STATUS 8'h1c

`define ACLM_CTRL_EN_BIT 0
`define ACLM_CTRL_FT_LSB 4
`define ACLM_ARP_HW_LSB 0
`define ACLM_ARP_PSPACE_LSB 4
`define ACLM_IP_PMODE_LSB 0
`define ACLM_IP_TTL_LSB 4
`define ACLM_IP_FRAG_LSB 6
`define ACLM_IP_OPT_LSB 8
`define ACLM_IP_SRC_LSB 12
`define ACLM_IP_DST_LSB 14
`define ACLM_IP_PVAL_LSB 16
`define ACLM_STAT_CNT_LSB 0
`define ACLM_STAT_LAST_BIT 16

`define ACLM_RST_WORD 32'h0000_0000
`define ACLM_RST_COUNT 16'h0000
`define ACLM_COUNT_MAX 16'hffff

`define ACLM_HW_ETHERNET 16'h0001
`define ACLM_PSPACE_IP 16'h0800
`define ACLM_IPPROTO_ICMP 8'h01
`define ACLM_IPPROTO_UDP 8'h11
`define ACLM_IPPROTO_TCP 8'h06

`endif

// file: hdl/aclm_pkg.sv
// types and shared functions of the entry matcher
package aclm_pkg;

  typedef enum logic [1:0] {
    ACLM_FT_ANY = 2'h0,
    ACLM_FT_ARP = 2'h1,
    ACLM_FT_IPV4 = 2'h2
  } aclm_ftype_t;

  typedef enum logic [1:0] {
    ACLM_TRI_ANY = 2'h0,
    ACLM_TRI_NO = 2'h1,
    ACLM_TRI_YES = 2'h2
  } aclm_tri_t;

  typedef enum logic [2:0] {
    ACLM_PR_ANY = 3'h0,
    ACLM_PR_SPEC = 3'h1,
    ACLM_PR_ICMP = 3'h2,
    ACLM_PR_UDP = 3'h3,
    ACLM_PR_TCP = 3'h4
  } aclm_proto_t;

  typedef enum logic [1:0] {
    ACLM_AD_ANY = 2'h0,
    ACLM_AD_HOST = 2'h1,
    ACLM_AD_NET = 2'h2
  } aclm_addr_t;

  typedef struct packed {
    logic enable;
    aclm_ftype_t ftype;
    aclm_tri_t arp_hw;
    aclm_tri_t arp_pspace;
    aclm_proto_t proto_mode;
    logic [7:0] proto_val;
    aclm_tri_t ttl;
    aclm_tri_t frag;
    aclm_tri_t opt;
    aclm_addr_t src_mode;
    aclm_addr_t dst_mode;
    logic [31:0] src_addr;
    logic [31:0] src_mask;
    logic [31:0] dst_addr;
    logic [31:0] dst_mask;
  } aclm_cfg_t;

  typedef struct packed {
    aclm_cfg_t cfg;
    logic [31:0] rdata;
    logic match_valid;
    logic match_hit;
    logic icmp_en;
    logic udp_en;
    logic tcp_en;
    logic last_hit;
    logic [15:0] hit_count;
  } aclm_state_t;

  // reserved codes fall through to don't-care
  function automatic logic aclm_tri_ok(aclm_tri_t mode, logic cond);
    case (mode)
      ACLM_TRI_NO: aclm_tri_ok = !cond;
      ACLM_TRI_YES: aclm_tri_ok = cond;
      default: aclm_tri_ok = 1'b1;
    endcase
  endfunction : aclm_tri_ok

  function automatic logic aclm_addr_ok(aclm_addr_t mode, logic [31:0] addr,
                                        logic [31:0] cfg, logic [31:0] mask);
    case (mode)
      ACLM_AD_HOST: aclm_addr_ok = (addr == cfg);
      ACLM_AD_NET: aclm_addr_ok = ((addr & mask) == (cfg & mask));
      default: aclm_addr_ok = 1'b1;
    endcase
  endfunction : aclm_addr_ok

endpackage : aclm_pkg

// file: hdl/aclm_ip_if.sv
// carrier between the matcher top and its ipv4 evaluator
`timescale 1ns/1ps
`default_nettype none

interface aclm_ip_if;
  import aclm_pkg::*;
  aclm_cfg_t cfg;
  logic [7:0] proto;
  logic [7:0] ttl;
  logic more_frag;
  logic [12:0] frag_pos;
  logic has_opt;
  logic [31:0] src;
  logic [31:0] dst;
  logic ip_ok;
  logic icmp_en;
  logic udp_en;
  logic tcp_en;

  modport eval (
    input cfg, proto, ttl, more_frag, frag_pos, has_opt, src, dst,
    output ip_ok, icmp_en, udp_en, tcp_en
  );
  modport ctl (
    output cfg, proto, ttl, more_frag, frag_pos, has_opt, src, dst,
    input ip_ok, icmp_en, udp_en, tcp_en
  );
endinterface : aclm_ip_if

`default_nettype wire

// file: hdl/aclm_ipv4_eval.sv
// ipv4 header criteria of one entry, purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "aclm_defines.svh"

module aclm_ipv4_eval
  import aclm_pkg::*;
(
  aclm_ip_if.eval ipi
);

  logic proto_ok;

  always_comb
  begin
    case (ipi.cfg.proto_mode)
      ACLM_PR_SPEC: proto_ok = (ipi.proto == ipi.cfg.proto_val);
      ACLM_PR_ICMP: proto_ok = (ipi.proto == `ACLM_IPPROTO_ICMP);
      ACLM_PR_UDP: proto_ok = (ipi.proto == `ACLM_IPPROTO_UDP);
      ACLM_PR_TCP: proto_ok = (ipi.proto == `ACLM_IPPROTO_TCP);
      default: proto_ok = 1'b1;
    endcase
  end

  // the follow-on protocol criteria live outside this block
  assign ipi.icmp_en = (ipi.cfg.proto_mode == ACLM_PR_ICMP);
  assign ipi.udp_en = (ipi.cfg.proto_mode == ACLM_PR_UDP);
  assign ipi.tcp_en = (ipi.cfg.proto_mode == ACLM_PR_TCP);

  assign ipi.ip_ok = proto_ok
    & aclm_tri_ok(ipi.cfg.ttl, ipi.ttl != 8'h00)
    & aclm_tri_ok(ipi.cfg.frag, ipi.more_frag | (ipi.frag_pos != 13'h0000))
    & aclm_tri_ok(ipi.cfg.opt, ipi.has_opt)
    & aclm_addr_ok(ipi.cfg.src_mode, ipi.src, ipi.cfg.src_addr, ipi.cfg.src_mask)
    & aclm_addr_ok(ipi.cfg.dst_mode, ipi.dst, ipi.cfg.dst_addr, ipi.cfg.dst_mask);

endmodule : aclm_ipv4_eval

`default_nettype wire

// file: hdl/aclm_matcher.sv
// header matcher of one access_control_entry: arp and ipv4 criteria, register port
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "aclm_defines.svh"

module aclm_matcher
  import aclm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic hdr_valid,
  input wire logic hdr_is_arp,
  input wire logic hdr_is_ipv4,
  input wire logic [15:0] hdr_hardware_address_space,
  input wire logic [15:0] hdr_protocol_address_space,
  input wire logic [7:0] hdr_ip_proto,
  input wire logic [7:0] hdr_ip_ttl,
  input wire logic hdr_more_fragments_flag,
  input wire logic [12:0] hdr_fragment_position,
  input wire logic hdr_ip_has_options,
  input wire logic [31:0] hdr_ip_src,
  input wire logic [31:0] hdr_ip_dst,
  output logic match_valid,
  output logic match_hit,
  output logic icmp_criteria_en,
  output logic udp_criteria_en,
  output logic tcp_criteria_en
);

  aclm_state_t s_q;
  aclm_state_t s_d;
  aclm_ip_if ipi ();
  logic arp_ok;
  logic hit_c;

  assign ipi.cfg = s_q.cfg;
  assign ipi.proto = hdr_ip_proto;
  assign ipi.ttl = hdr_ip_ttl;
  assign ipi.more_frag = hdr_more_fragments_flag;
  assign ipi.frag_pos = hdr_fragment_position;
  assign ipi.has_opt = hdr_ip_has_options;
  assign ipi.src = hdr_ip_src;
  assign ipi.dst = hdr_ip_dst;

  aclm_ipv4_eval u_ipv4 (
    .ipi(ipi.eval)
  );

  assign arp_ok = aclm_tri_ok(s_q.cfg.arp_hw,
                    hdr_hardware_address_space == `ACLM_HW_ETHERNET)
                & aclm_tri_ok(s_q.cfg.arp_pspace,
                    hdr_protocol_address_space == `ACLM_PSPACE_IP);

  always_comb
  begin
    case (s_q.cfg.ftype)
      ACLM_FT_ANY: hit_c = 1'b1;
      ACLM_FT_ARP: hit_c = hdr_is_arp & arp_ok;
      ACLM_FT_IPV4: hit_c = hdr_is_ipv4 & ipi.ip_ok;
      default: hit_c = 1'b0;
    endcase
    hit_c = hit_c & s_q.cfg.enable;
  end

  always_comb
  begin
    s_d = s_q;
    s_d.rdata = `ACLM_RST_WORD;
    s_d.match_valid = 1'b0;
    if (reg_wr)
    begin
      case (reg_addr)
        `ACLM_OFF_CTRL:
        begin
          s_d.cfg.enable = reg_wdata[`ACLM_CTRL_EN_BIT];
          s_d.cfg.ftype = aclm_ftype_t'(reg_wdata[`ACLM_CTRL_FT_LSB +: 2]);
        end
        `ACLM_OFF_ARP:
        begin
          s_d.cfg.arp_hw = aclm_tri_t'(reg_wdata[`ACLM_ARP_HW_LSB +: 2]);
          s_d.cfg.arp_pspace = aclm_tri_t'(reg_wdata[`ACLM_ARP_PSPACE_LSB +: 2]);
        end
        `ACLM_OFF_IP:
        begin
          s_d.cfg.proto_mode = aclm_proto_t'(reg_wdata[`ACLM_IP_PMODE_LSB +: 3]);
          s_d.cfg.ttl = aclm_tri_t'(reg_wdata[`ACLM_IP_TTL_LSB +: 2]);
          s_d.cfg.frag = aclm_tri_t'(reg_wdata[`ACLM_IP_FRAG_LSB +: 2]);
          s_d.cfg.opt = aclm_tri_t'(reg_wdata[`ACLM_IP_OPT_LSB +: 2]);
          s_d.cfg.src_mode = aclm_addr_t'(reg_wdata[`ACLM_IP_SRC_LSB +: 2]);
          s_d.cfg.dst_mode = aclm_addr_t'(reg_wdata[`ACLM_IP_DST_LSB +: 2]);
          s_d.cfg.proto_val = reg_wdata[`ACLM_IP_PVAL_LSB +: 8];
        end
        `ACLM_OFF_SRC_ADDR: s_d.cfg.src_addr = reg_wdata;
        `ACLM_OFF_SRC_MASK: s_d.cfg.src_mask = reg_wdata;
        `ACLM_OFF_DST_ADDR: s_d.cfg.dst_addr = reg_wdata;
        `ACLM_OFF_DST_MASK: s_d.cfg.dst_mask = reg_wdata;
        // any write to status clears the counter; a hit below still counts
        `ACLM_OFF_STATUS: s_d.hit_count = `ACLM_RST_COUNT;
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        `ACLM_OFF_CTRL:
        begin
          s_d.rdata[`ACLM_CTRL_EN_BIT] = s_q.cfg.enable;
          s_d.rdata[`ACLM_CTRL_FT_LSB +: 2] = s_q.cfg.ftype;
        end
        `ACLM_OFF_ARP:
        begin
          s_d.rdata[`ACLM_ARP_HW_LSB +: 2] = s_q.cfg.arp_hw;
          s_d.rdata[`ACLM_ARP_PSPACE_LSB +: 2] = s_q.cfg.arp_pspace;
        end
        `ACLM_OFF_IP:
        begin
          s_d.rdata[`ACLM_IP_PMODE_LSB +: 3] = s_q.cfg.proto_mode;
          s_d.rdata[`ACLM_IP_TTL_LSB +: 2] = s_q.cfg.ttl;
          s_d.rdata[`ACLM_IP_FRAG_LSB +: 2] = s_q.cfg.frag;
          s_d.rdata[`ACLM_IP_OPT_LSB +: 2] = s_q.cfg.opt;
          s_d.rdata[`ACLM_IP_SRC_LSB +: 2] = s_q.cfg.src_mode;
          s_d.rdata[`ACLM_IP_DST_LSB +: 2] = s_q.cfg.dst_mode;
          s_d.rdata[`ACLM_IP_PVAL_LSB +: 8] = s_q.cfg.proto_val;
        end
        `ACLM_OFF_SRC_ADDR: s_d.rdata = s_q.cfg.src_addr;
        `ACLM_OFF_SRC_MASK: s_d.rdata = s_q.cfg.src_mask;
        `ACLM_OFF_DST_ADDR: s_d.rdata = s_q.cfg.dst_addr;
        `ACLM_OFF_DST_MASK: s_d.rdata = s_q.cfg.dst_mask;
        `ACLM_OFF_STATUS:
        begin
          s_d.rdata[`ACLM_STAT_CNT_LSB +: 16] = s_q.hit_count;
          s_d.rdata[`ACLM_STAT_LAST_BIT] = s_q.last_hit;
        end
        default: ;
      endcase
    end
    // a header is judged against the settings held before this edge
    if (hdr_valid)
    begin
      s_d.match_valid = 1'b1;
      s_d.match_hit = hit_c;
      s_d.last_hit = hit_c;
      s_d.icmp_en = ipi.icmp_en & (s_q.cfg.ftype == ACLM_FT_IPV4);
      s_d.udp_en = ipi.udp_en & (s_q.cfg.ftype == ACLM_FT_IPV4);
      s_d.tcp_en = ipi.tcp_en & (s_q.cfg.ftype == ACLM_FT_IPV4);
      // saturate rather than wrap so software never sees a small count after many hits
      if (hit_c && (s_d.hit_count != `ACLM_COUNT_MAX))
      begin
        s_d.hit_count = s_d.hit_count + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign match_valid = s_q.match_valid;
  assign match_hit = s_q.match_hit;
  assign icmp_criteria_en = s_q.icmp_en;
  assign udp_criteria_en = s_q.udp_en;
  assign tcp_criteria_en = s_q.tcp_en;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic ipv4_entry;
  assign ipv4_entry = hdr_valid & s_q.cfg.enable & (s_q.cfg.ftype == ACLM_FT_IPV4) & hdr_is_ipv4;

  sequence hdr_judged;
    hdr_valid ##1 match_valid;
  endsequence

  hdr_latency_a: assert property (hdr_valid |-> hdr_judged)
    else $error("match result not one cycle after header");

  arp_hw_a: assert property (
    hdr_valid && (s_q.cfg.ftype == ACLM_FT_ARP) && (s_q.cfg.arp_hw == ACLM_TRI_YES)
    && (hdr_hardware_address_space != `ACLM_HW_ETHERNET) |=> !match_hit)
    else $error("arp hit with non-ethernet hardware space");

  arp_pspace_a: assert property (
    hdr_valid && (s_q.cfg.ftype == ACLM_FT_ARP) && (s_q.cfg.arp_pspace == ACLM_TRI_YES)
    && (hdr_protocol_address_space != `ACLM_PSPACE_IP) |=> !match_hit)
    else $error("arp hit with non-ip protocol space");

  all_any_a: assert property (
    hdr_valid && s_q.cfg.enable && (s_q.cfg.ftype == ACLM_FT_ANY) |=> match_valid && match_hit)
    else $error("don't-care entry failed to hit");

  ipv4_only_a: assert property (
    hdr_valid && (s_q.cfg.ftype == ACLM_FT_IPV4) && !hdr_is_ipv4 |=> !match_hit)
    else $error("non-ipv4 frame hit ipv4 entry");

  proto_val_a: assert property (
    ipv4_entry && (s_q.cfg.proto_mode == ACLM_PR_SPEC)
    && (hdr_ip_proto != s_q.cfg.proto_val) |=> !match_hit)
    else $error("hit with wrong protocol value");

  l4_enable_a: assert property (
    hdr_valid && (s_q.cfg.ftype == ACLM_FT_IPV4) && (s_q.cfg.proto_mode == ACLM_PR_TCP)
    |=> tcp_criteria_en && !udp_criteria_en && !icmp_criteria_en)
    else $error("tcp extra criteria not enabled");

  ttl_zero_a: assert property (
    ipv4_entry && (s_q.cfg.ttl == ACLM_TRI_NO) && (hdr_ip_ttl != 8'h00) |=> !match_hit)
    else $error("hit with lifetime above zero");

  frag_no_a: assert property (
    ipv4_entry && (s_q.cfg.frag == ACLM_TRI_NO)
    && (hdr_more_fragments_flag || (hdr_fragment_position != 13'h0000)) |=> !match_hit)
    else $error("fragment hit while fragments blocked");

  opt_no_a: assert property (
    ipv4_entry && (s_q.cfg.opt == ACLM_TRI_NO) && hdr_ip_has_options |=> !match_hit)
    else $error("hit with options while options blocked");

  src_host_a: assert property (
    ipv4_entry && (s_q.cfg.src_mode == ACLM_AD_HOST)
    && (hdr_ip_src != s_q.cfg.src_addr) |=> !match_hit)
    else $error("hit with wrong source host");

  src_net_a: assert property (
    ipv4_entry && (s_q.cfg.src_mode == ACLM_AD_NET)
    && ((hdr_ip_src & s_q.cfg.src_mask) != (s_q.cfg.src_addr & s_q.cfg.src_mask))
    |=> !match_hit)
    else $error("hit with source outside network");

  dst_host_a: assert property (
    ipv4_entry && (s_q.cfg.dst_mode == ACLM_AD_HOST)
    && (hdr_ip_dst != s_q.cfg.dst_addr) |=> !match_hit)
    else $error("hit with wrong destination host");

  dst_net_a: assert property (
    ipv4_entry && (s_q.cfg.dst_mode == ACLM_AD_NET)
    && ((hdr_ip_dst & s_q.cfg.dst_mask) != (s_q.cfg.dst_addr & s_q.cfg.dst_mask))
    |=> !match_hit)
    else $error("hit with destination outside network");

  ttl_live_a: assert property (
    ipv4_entry && (s_q.cfg.ttl == ACLM_TRI_YES) && (hdr_ip_ttl == 8'h00) |=> !match_hit)
    else $error("hit with zero lifetime while non-zero required");

  frag_yes_a: assert property (
    ipv4_entry && (s_q.cfg.frag == ACLM_TRI_YES)
    && !hdr_more_fragments_flag && (hdr_fragment_position == 13'h0000) |=> !match_hit)
    else $error("unfragmented hit while fragments required");

  opt_yes_a: assert property (
    ipv4_entry && (s_q.cfg.opt == ACLM_TRI_YES) && !hdr_ip_has_options |=> !match_hit)
    else $error("hit without options while options required");

  icmp_only_a: assert property (
    ipv4_entry && (s_q.cfg.proto_mode == ACLM_PR_ICMP)
    && (hdr_ip_proto != `ACLM_IPPROTO_ICMP) |=> !match_hit)
    else $error("icmp entry hit by another protocol");

  entry_off_a: assert property (
    hdr_valid && !s_q.cfg.enable |=> match_valid && !match_hit)
    else $error("disabled entry reported a hit");

  l4_off_a: assert property (
    hdr_valid && (s_q.cfg.ftype != ACLM_FT_IPV4)
    |=> !icmp_criteria_en && !udp_criteria_en && !tcp_criteria_en)
    else $error("extra criteria enabled for non-ipv4 entry");

  valid_pulse_a: assert property (!hdr_valid |=> !match_valid)
    else $error("match result without header");

  // a hit in the clearing cycle legally leaves a count of one
  count_clear_a: assert property (
    reg_wr && (reg_addr == `ACLM_OFF_STATUS) && !hdr_valid |=> s_q.hit_count == 16'h0000)
    else $error("hit counter not cleared by status write");

  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read answer");

endmodule : aclm_matcher

`default_nettype wire

// file: verif/aclm_hdr_src.sv
// header source model standing in for the ingress parser
`timescale 1ns/1ps
`default_nettype none

module aclm_hdr_src (
  input wire logic clk,
  output logic hdr_valid,
  output wire logic hdr_is_arp,
  output wire logic hdr_is_ipv4,
  output wire logic [15:0] hdr_hardware_address_space,
  output wire logic [15:0] hdr_protocol_address_space,
  output wire logic [7:0] hdr_ip_proto,
  output wire logic [7:0] hdr_ip_ttl,
  output wire logic hdr_more_fragments_flag,
  output wire logic [12:0] hdr_fragment_position,
  output wire logic hdr_ip_has_options,
  output wire logic [31:0] hdr_ip_src,
  output wire logic [31:0] hdr_ip_dst
);
  logic [128:0] f;

  assign {hdr_is_arp, hdr_is_ipv4, hdr_hardware_address_space, hdr_protocol_address_space,
          hdr_ip_proto, hdr_ip_ttl, hdr_more_fragments_flag, hdr_fragment_position,
          hdr_ip_has_options, hdr_ip_src, hdr_ip_dst} = f;

  initial
  begin
    hdr_valid = 1'b0;
    f = '0;
  end

  // fields go to their inverse once dropped so stale values never pass as live
  task automatic put(input logic [128:0] h);
    @(posedge clk);
    hdr_valid <= 1'b1;
    f <= h;
    @(posedge clk);
    hdr_valid <= 1'b0;
    f <= ~h;
  endtask : put
endmodule : aclm_hdr_src

`default_nettype wire

// file: verif/aclm_matcher_tb_top.sv
// self-checking bench of the entry matcher
`timescale 1ns/1ps
`default_nettype none

module aclm_matcher_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire logic [31:0] reg_rdata, hdr_ip_src, hdr_ip_dst;
  wire logic hdr_valid, hdr_is_arp, hdr_is_ipv4, hdr_more_fragments_flag, hdr_ip_has_options;
  wire logic [15:0] hdr_hardware_address_space, hdr_protocol_address_space;
  wire logic [7:0] hdr_ip_proto, hdr_ip_ttl;
  wire logic [12:0] hdr_fragment_position;
  wire logic match_valid, match_hit, icmp_criteria_en, udp_criteria_en, tcp_criteria_en;
  int errors = 0;
  int n_checks = 0;
  logic en;
  logic [1:0] ft, hw, pspace, ttl, frag, opt, sm, dm;
  logic [2:0] pm;
  logic [7:0] pv;
  logic [31:0] sa, sk, da, dk;
  logic [15:0] cnt;
  logic last;
  logic [7:0] codes [4] = '{8'h01, 8'h11, 8'h06, 8'h2f};

  always #2 clk = ~clk;

  aclm_hdr_src u_aclm_hdr_src (.clk, .hdr_valid, .hdr_is_arp, .hdr_is_ipv4,
    .hdr_hardware_address_space, .hdr_protocol_address_space, .hdr_ip_proto, .hdr_ip_ttl,
    .hdr_more_fragments_flag, .hdr_fragment_position, .hdr_ip_has_options, .hdr_ip_src,
    .hdr_ip_dst);

  aclm_matcher u_aclm_matcher (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .hdr_valid, .hdr_is_arp, .hdr_is_ipv4, .hdr_hardware_address_space,
    .hdr_protocol_address_space, .hdr_ip_proto, .hdr_ip_ttl, .hdr_more_fragments_flag,
    .hdr_fragment_position, .hdr_ip_has_options, .hdr_ip_src, .hdr_ip_dst, .match_valid,
    .match_hit, .icmp_criteria_en, .udp_criteria_en, .tcp_criteria_en);

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(what, reg_rdata, exp);
  endtask : rd

  function automatic logic tri_ok(input logic [1:0] m, input logic c);
    return m == 2'h1 ? !c : (m == 2'h2 ? c : 1'b1);
  endfunction : tri_ok

  function automatic logic ad_ok(input logic [1:0] m, input logic [31:0] a, c, k);
    return m == 2'h1 ? a == c : (m == 2'h2 ? (a & k) == (c & k) : 1'b1);
  endfunction : ad_ok

  function automatic logic exp_hit(input logic [128:0] h);
    logic arp, ip4, more, op, pok;
    logic [15:0] hf, pf;
    logic [7:0] pr, tl;
    logic [12:0] fp;
    logic [31:0] s, d;
    {arp, ip4, hf, pf, pr, tl, more, fp, op, s, d} = h;
    case (pm)
      3'h1: pok = pr == pv;
      3'h2: pok = pr == 8'h01;
      3'h3: pok = pr == 8'h11;
      3'h4: pok = pr == 8'h06;
      default: pok = 1'b1;
    endcase
    if (!en || ft == 2'h3)
      return 1'b0;
    if (ft == 2'h1)
      return arp && tri_ok(hw, hf == 16'h0001) && tri_ok(pspace, pf == 16'h0800);
    if (ft == 2'h2)
      return ip4 && pok && tri_ok(ttl, tl != 8'h00) && tri_ok(frag, more || fp != 13'h0)
        && tri_ok(opt, op) && ad_ok(sm, s, sa, sk) && ad_ok(dm, d, da, dk);
    return 1'b1;
  endfunction : exp_hit

  function automatic logic [31:0] pick(input logic [31:0] a, k);
    case ($urandom_range(0, 2))
      0: return a;
      1: return a ^ (~k & $urandom);
      default: return $urandom;
    endcase
  endfunction : pick

  task automatic put_cfg();
    wr(8'h00, {26'h0, ft, 3'h0, en});
    wr(8'h04, {26'h0, pspace, 2'h0, hw});
    wr(8'h08, {8'h0, pv, dm, sm, 2'h0, opt, frag, ttl, 1'h0, pm});
    wr(8'h0c, sa);
    wr(8'h10, sk);
    wr(8'h14, da);
    wr(8'h18, dk);
  endtask : put_cfg

  task automatic send(input logic [128:0] h);
    logic e;
    e = exp_hit(h);
    u_aclm_hdr_src.put(h);
    #1;
    check("match_valid", match_valid, 1'b1);
    check("match_hit", match_hit, e);
    if (en)
    begin
      check("icmp_en", icmp_criteria_en, ft == 2'h2 && pm == 3'h2);
      check("udp_en", udp_criteria_en, ft == 2'h2 && pm == 3'h3);
      check("tcp_en", tcp_criteria_en, ft == 2'h2 && pm == 3'h4);
    end
    if (e && cnt != 16'hffff)
      cnt++;
    last = e;
  endtask : send

  initial
  begin
    repeat (100000) @(posedge clk);
    errors++;
    finish_test();
  end

  initial
  begin
    logic [7:0] pr;
    void'($urandom(74));
    {en, ft, hw, pspace, ttl, frag, opt, sm, dm, pm, pv, sa, sk, da, dk, cnt, last} = '0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 36; a += 4)
      rd(8'(a), 32'h0, "reset word");
    // every protocol mode against each coded protocol and the custom value
    {en, ft, pv} = {1'b1, 2'h2, 8'h2f};
    for (int m = 0; m < 5; m++)
    begin
      pm = 3'(m);
      put_cfg();
      foreach (codes[i])
      begin
        pr = codes[i];
        send({2'b01, 32'h0, pr, 8'h40, 1'b0, 13'h0, 1'b0, 64'h0});
      end
    end
    @(posedge clk);
    #1;
    check("match_valid drop", match_valid, 1'b0);
    repeat (200)
    begin
      en = $urandom_range(0, 7) != 0;
      // all 27 bits random, else frame type would stay at Any
      {ft, hw, pspace, ttl, frag, opt, sm, dm, pm, pv} = 27'($urandom);
      {sa, sk, da, dk} = {$urandom, $urandom, $urandom, $urandom};
      put_cfg();
      rd(8'h08, {8'h0, pv, dm, sm, 2'h0, opt, frag, ttl, 1'h0, pm}, "ip word");
      repeat (4)
      begin
        case ($urandom_range(0, 4))
          0: pr = 8'h01;
          1: pr = 8'h11;
          2: pr = 8'h06;
          3: pr = pv;
          default: pr = 8'($urandom);
        endcase
        send({1'($urandom), 1'($urandom),
          ($urandom_range(0, 1) ? 16'h0001 : 16'($urandom)),
          ($urandom_range(0, 1) ? 16'h0800 : 16'($urandom)), pr,
          ($urandom_range(0, 1) ? 8'h00 : 8'($urandom)), 1'($urandom),
          ($urandom_range(0, 1) ? 13'h0 : 13'($urandom)), 1'($urandom),
          pick(sa, sk), pick(da, dk)});
      end
    end
    rd(8'h1c, {15'h0, last, cnt}, "status");
    wr(8'h1c, 32'h0);
    cnt = 16'h0;
    rd(8'h1c, {15'h0, last, cnt}, "status cleared");
    finish_test();
  end
endmodule : aclm_matcher_tb_top

`default_nettype wire
